// [hdl/alu_flag_datapath.sv]
// Implementation choice: the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
module alu_flag_datapath (
    input  wire logic                       aclk,            // Core clock, 100 MHz
    input  wire logic                       aresetn,         // Synchronous reset, active low
    input  wire logic [alu_pkg::ADDR_W-1:0] awaddr,          // Write address
    input  wire logic [2:0]                 awprot,          // Write protection, unused
    input  wire logic                       awvalid,         // Write address valid
    output logic                            awready,         // Write address ready
    input  wire logic [31:0]                wdata,           // Write data
    input  wire logic [3:0]                 wstrb,           // Write strobes
    input  wire logic                       wvalid,          // Write data valid
    output logic                            wready,          // Write data ready
    output logic [1:0]                      bresp,           // Write response
    output logic                            bvalid,          // Write response valid
    input  wire logic                       bready,          // Write response ready
    input  wire logic [alu_pkg::ADDR_W-1:0] araddr,          // Read address
    input  wire logic [2:0]                 arprot,          // Read protection, unused
    input  wire logic                       arvalid,         // Read address valid
    output logic                            arready,         // Read address ready
    output logic [31:0]                     rdata,           // Read data
    output logic [1:0]                      rresp,           // Read response
    output logic                            rvalid,          // Read data valid
    input  wire logic                       rready,          // Read data ready
    input  wire logic [7:0]                 io_flag_events,  // Flag set pulses for clear-on-one register
    output logic [7:0]                      dest_value,      // Destination register
    output logic [7:0]                      flag_register    // Processor flags
);
    import alu_pkg::*;

    typedef struct packed {
        logic                        awready;
        logic                        wready;
        logic                        bvalid;
        logic [1:0]                  bresp;
        logic                        arready;
        logic                        rvalid;
        logic [1:0]                  rresp;
        logic [31:0]                 rdata;
        logic                        aw_got;
        logic                        w_got;
        logic [8:0]                  waddr;
        logic [31:0]                 wdata;
        logic [3:0]                  wstrb;
        logic [7:0]                  dest;
        logic [7:0]                  src;
        logic [7:0]                  imm;
        logic [7:0]                  flags;
        logic [31:0]                 cmd;
        logic                        io_refused;
        logic [IO_COUNT-1:0][7:0]    io_mem;
    } state_t;

    localparam state_t STATE_RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};

    state_t     s_reg;
    state_t     s_next;
    logic       wr_do;
    logic       cmd_fire;
    logic       io_win_wr;
    logic [7:0] wbyte;
    logic [5:0] io_addr;
    logic [7:0] io_old;
    logic [7:0] io_mask;
    logic [7:0] io_val;
    alu_if      abus ();

    // ************************************************************
    // Arithmetic unit
    // ************************************************************
    assign abus.op       = alu_op_t'(s_reg.wdata[CMD_OP_LSB +: 5]);
    assign abus.a        = s_reg.dest;
    assign abus.b        = s_reg.src;
    assign abus.k        = s_reg.imm;
    assign abus.flags_in = s_reg.flags;

    alu_core u_alu (
        .bus (abus)
    );

    // Write into the I/O space, honouring clear-on-one bits
    function automatic logic [7:0] io_write(input logic [4:0] idx, input logic [7:0] old, input logic [7:0] d);
        io_write = (idx == IO_W1C_ADDR) ? (old & ~d) : d;
    endfunction

    // Decode helpers for the pending write
    assign wr_do     = s_reg.aw_got && s_reg.w_got;
    assign wbyte     = s_reg.wdata[7:0];
    assign cmd_fire  = wr_do && s_reg.wstrb[0] && (s_reg.waddr == CMD_OFF);
    assign io_win_wr = wr_do && s_reg.wstrb[0] && (s_reg.waddr[8:7] == IO_WIN_SEL) && (s_reg.waddr[1:0] == 2'h0);
    assign io_addr   = s_reg.wdata[CMD_IO_LSB +: 6];
    assign io_old    = s_reg.io_mem[io_addr[4:0]];
    assign io_mask   = 8'(8'h01 << s_reg.wdata[CMD_BIT_LSB +: 3]);
    assign io_val    = (abus.op == OP_IOSET) ? (io_old | io_mask) : (io_old & ~io_mask);

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb
    begin
        s_next = s_reg;
        // Write address and data taken independently
        if (s_reg.awready && awvalid)
        begin
            s_next.awready = 1'b0;
            s_next.aw_got = 1'b1;
            s_next.waddr = awaddr;
        end
        if (s_reg.wready && wvalid)
        begin
            s_next.wready = 1'b0;
            s_next.w_got = 1'b1;
            s_next.wdata = wdata;
            s_next.wstrb = wstrb;
        end
        // Perform the write once both halves are held
        if (wr_do)
        begin
            s_next.aw_got = 1'b0;
            s_next.w_got = 1'b0;
            s_next.bvalid = 1'b1;
            s_next.bresp = RESP_OKAY;
            if (s_reg.waddr[8:7] == IO_WIN_SEL && s_reg.waddr[1:0] == 2'h0)
            begin
                if (s_reg.wstrb[0])
                    s_next.io_mem[s_reg.waddr[6:2]] = io_write(s_reg.waddr[6:2], s_reg.io_mem[s_reg.waddr[6:2]], wbyte);
            end
            else
            begin
                case (s_reg.waddr)
                    DEST_OFF   : if (s_reg.wstrb[0]) s_next.dest = wbyte;
                    SRC_OFF    : if (s_reg.wstrb[0]) s_next.src = wbyte;
                    IMM_OFF    : if (s_reg.wstrb[0]) s_next.imm = wbyte;
                    STATUS_OFF : if (s_reg.wstrb[0]) s_next.flags = wbyte;
                    INFO_OFF   : ;
                    CMD_OFF    : ;
                    default    : s_next.bresp = RESP_SLVERR;
                endcase
            end
        end
        // Command executes in the cycle it is written
        if (cmd_fire)
        begin
            s_next.cmd = s_reg.wdata;
            s_next.io_refused = 1'b0;
            if (abus.wr_dest)
                s_next.dest = abus.res;
            s_next.flags = abus.flags_out;
            if (abus.op == OP_IOSET || abus.op == OP_IOCLR)
            begin
                if (io_addr > IO_LAST)
                    s_next.io_refused = 1'b1;
                else
                    s_next.io_mem[io_addr[4:0]] = io_write(io_addr[4:0], io_old, io_val);
            end
        end
        // Hardware flag set wins over a same-cycle clear
        s_next.io_mem[IO_W1C_ADDR] = s_next.io_mem[IO_W1C_ADDR] | io_flag_events;
        if (s_reg.bvalid && bready)
        begin
            s_next.bvalid = 1'b0;
            s_next.awready = 1'b1;
            s_next.wready = 1'b1;
        end
        // Read channel
        if (s_reg.arready && arvalid)
        begin
            s_next.arready = 1'b0;
            s_next.rvalid = 1'b1;
            s_next.rresp = RESP_OKAY;
            s_next.rdata = '0;
            if (araddr[8:7] == IO_WIN_SEL && araddr[1:0] == 2'h0)
                s_next.rdata = {24'h0, s_reg.io_mem[araddr[6:2]]};
            else
            begin
                case (araddr)
                    DEST_OFF   : s_next.rdata = {24'h0, s_reg.dest};
                    SRC_OFF    : s_next.rdata = {24'h0, s_reg.src};
                    IMM_OFF    : s_next.rdata = {24'h0, s_reg.imm};
                    STATUS_OFF : s_next.rdata = {24'h0, s_reg.flags};
                    CMD_OFF    : s_next.rdata = s_reg.cmd;
                    INFO_OFF   : s_next.rdata = {31'h0, s_reg.io_refused};
                    default    : s_next.rresp = RESP_SLVERR;
                endcase
            end
        end
        if (s_reg.rvalid && rready)
        begin
            s_next.rvalid = 1'b0;
            s_next.arready = 1'b1;
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            s_reg <= STATE_RST;
        else
            s_reg <= s_next;
    end

    // Outputs straight from the state register
    assign awready       = s_reg.awready;
    assign wready        = s_reg.wready;
    assign bvalid        = s_reg.bvalid;
    assign bresp         = s_reg.bresp;
    assign arready       = s_reg.arready;
    assign rvalid        = s_reg.rvalid;
    assign rresp         = s_reg.rresp;
    assign rdata         = s_reg.rdata;
    assign dest_value    = s_reg.dest;
    assign flag_register = s_reg.flags;

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // One bit per op code, high while that command executes; a plain net so properties sample it
    logic [31:0] fired;
    assign fired = cmd_fire ? 32'(32'h1 << abus.op) : 32'h0;

    a_add_sum: assert property (fired[OP_ADD] |=> s_reg.dest == 8'($past(s_reg.dest) + $past(s_reg.src)))
        else $error("add result wrong");
    a_adc_carry: assert property (fired[OP_ADC] |=> s_reg.flags[FLAG_C] ==
        (({1'b0, $past(s_reg.dest)} + {1'b0, $past(s_reg.src)} + 9'($past(s_reg.flags[FLAG_C]))) > 9'h0ff))
        else $error("add with carry flag wrong");
    a_difference_imm_borrow: assert property (fired[OP_DIFFERENCE_IMM] |=> s_reg.flags[FLAG_C] == ($past(s_reg.dest) < $past(s_reg.imm))
        && s_reg.dest == 8'($past(s_reg.dest) - $past(s_reg.imm)))
        else $error("subtract constant wrong");
    a_sbc_result: assert property (fired[OP_SBC] |=>
        s_reg.dest == 8'($past(s_reg.dest) - $past(s_reg.src) - 8'($past(s_reg.flags[FLAG_C]))))
        else $error("subtract with borrow wrong");
    a_and_keeps_ch: assert property ((fired[OP_AND] || fired[OP_CONJUNCTION_IMM]) |=> s_reg.flags[FLAG_C] == $past(s_reg.flags[FLAG_C])
        && s_reg.flags[FLAG_H] == $past(s_reg.flags[FLAG_H]) && !s_reg.flags[FLAG_V])
        else $error("and touched carry or half carry");
    a_eor_zero_flag: assert property (fired[OP_EOR] |=> s_reg.flags[FLAG_Z] == (s_reg.dest == 8'h00)
        && s_reg.flags[FLAG_C] == $past(s_reg.flags[FLAG_C]))
        else $error("xor flags wrong");
    a_com_value: assert property (fired[OP_COM] |=> s_reg.dest == ~$past(s_reg.dest) && s_reg.flags[FLAG_C]
        && s_reg.flags[FLAG_H] == $past(s_reg.flags[FLAG_H]))
        else $error("complement wrong");
    a_inc_keeps_c: assert property (fired[OP_INC] |=> s_reg.dest == 8'($past(s_reg.dest) + 8'h01)
        && s_reg.flags[FLAG_C] == $past(s_reg.flags[FLAG_C]))
        else $error("increment wrong");
    a_dec_overflow: assert property (fired[OP_DEC] |=> s_reg.flags[FLAG_V] == ($past(s_reg.dest) == 8'h80)
        && s_reg.flags[FLAG_C] == $past(s_reg.flags[FLAG_C]))
        else $error("decrement flags wrong");
    a_tst_unchanged: assert property (fired[OP_TST] |=> s_reg.dest == $past(s_reg.dest)
        && s_reg.flags[FLAG_N] == s_reg.dest[7])
        else $error("test changed value");
    a_clr_zero: assert property (fired[OP_CLR] |=> s_reg.dest == 8'h00 && s_reg.flags[FLAG_Z])
        else $error("clear wrong");
    a_sbr_bits: assert property (fired[OP_SBR] |=> s_reg.dest == ($past(s_reg.dest) | $past(s_reg.imm)))
        else $error("set bits wrong");
    a_cbr_bits: assert property (fired[OP_CBR] |=> s_reg.dest == ($past(s_reg.dest) & ~$past(s_reg.imm)))
        else $error("clear bits wrong");
    a_neg_value: assert property (fired[OP_NEG] |=> s_reg.dest == 8'(8'h00 - $past(s_reg.dest))
        && s_reg.flags[FLAG_C] == ($past(s_reg.dest) != 8'h00))
        else $error("negate wrong");
    a_ser_no_flags: assert property (fired[OP_SER] |=> s_reg.dest == 8'hff && s_reg.flags == $past(s_reg.flags))
        else $error("fill ones wrong");
    a_w1c_clears: assert property (io_win_wr && s_reg.waddr[6:2] == IO_W1C_ADDR && io_flag_events == 8'h00
        |=> (s_reg.io_mem[IO_W1C_ADDR] & $past(wbyte)) == 8'h00)
        else $error("clear on one failed");
    // A bit clear writes its own target as zero, so only that flag may survive
    a_rmw_clears_all: assert property ((fired[OP_IOSET] || fired[OP_IOCLR]) && io_addr == {1'b0, IO_W1C_ADDR}
        && io_flag_events == 8'h00 |=> s_reg.io_mem[IO_W1C_ADDR] ==
        ($past(fired[OP_IOCLR]) ? $past(io_old & io_mask) : 8'h00))
        else $error("read modify write left flag");
    a_io_range: assert property ((fired[OP_IOSET] || fired[OP_IOCLR]) && io_addr > IO_LAST && io_flag_events == 8'h00
        |=> s_reg.io_mem == $past(s_reg.io_mem) && s_reg.io_refused)
        else $error("bit op beyond range");

    c_add_cmd: cover property (fired[OP_ADD]);
    c_rmw_w1c: cover property (fired[OP_IOSET] && io_addr == {1'b0, IO_W1C_ADDR} && io_old != 8'h00);
    c_event_clear: cover property (io_win_wr && io_flag_events != 8'h00);
    c_refused: cover property (fired[OP_IOCLR] && io_addr > IO_LAST);
endmodule

// [hdl/alu_pkg.sv]
// Notes on behaviour
// - Add and add-with-carry take one clock, store, update Z C N V H.
// - Subtract register or constant from destination, store, update Z C N V H.
// - Subtract with borrow also subtracts carry, updates Z C N V H.
// - AND with register or constant updates Z N V, keeps C and H.
// - OR with register or constant and XOR store, update only Z N V S.
// - One's complement gives FF minus value, updates Z C N V, keeps H.
// - Increment adds one, updates Z N V, carry stays.
// - Decrement subtracts one, updates Z N V, carry stays.
// - Test ANDs register with itself, value unchanged, sets Z N V.
// - Clear XORs register with itself giving zero, updates Z N V.
// - Set-bits ORs destination with immediate mask, updates Z N V.
// - Clear-bits ANDs destination with FF minus mask, updates Z N V.
// - Some I/O flags clear when software writes one to them.
// - I/O bit set and clear rewrite whole register, clearing set flags.
// - I/O bit set and clear reach only addresses 00 to 1F.
package alu_pkg;
    // ************************************************************
    // Register map
    // ************************************************************
    localparam int         ADDR_W      = 9;
    localparam logic [8:0] DEST_OFF    = 9'h000;
    localparam logic [8:0] SRC_OFF     = 9'h004;
    localparam logic [8:0] IMM_OFF     = 9'h008;
    localparam logic [8:0] CMD_OFF     = 9'h00c;
    localparam logic [8:0] INFO_OFF    = 9'h010;
    localparam logic [7:0] STATUS_IDX  = 8'h3f;
    localparam logic [8:0] STATUS_OFF  = 9'(STATUS_IDX * 4);
    localparam logic [1:0] IO_WIN_SEL  = 2'h2;
    localparam int         IO_COUNT    = 32;
    localparam logic [5:0] IO_LAST     = 6'h1f;
    localparam logic [4:0] IO_W1C_ADDR = 5'h05;
    localparam logic [7:0] REG_RST     = 8'h00;
    localparam logic [7:0] BYTE_ONES   = 8'hff;
    // ************************************************************
    // Fields
    // ************************************************************
    localparam int         FLAG_C      = 0;
    localparam int         FLAG_Z      = 1;
    localparam int         FLAG_N      = 2;
    localparam int         FLAG_V      = 3;
    localparam int         FLAG_S      = 4;
    localparam int         FLAG_H      = 5;
    localparam int         CMD_OP_LSB  = 0;
    localparam int         CMD_BIT_LSB = 8;
    localparam int         CMD_IO_LSB  = 16;
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ************************************************************
    // Operations
    // ************************************************************
    typedef enum logic [4:0] {
        OP_ADD   = 5'h00, OP_ADC   = 5'h01, OP_SUB   = 5'h02, OP_DIFFERENCE_IMM  = 5'h03,
        OP_SBC   = 5'h04, OP_BORROW_DIFFERENCE_IMM  = 5'h05, OP_AND   = 5'h06, OP_CONJUNCTION_IMM  = 5'h07,
        OP_OR    = 5'h08, OP_ORI   = 5'h09, OP_EOR   = 5'h0a, OP_COM   = 5'h0b,
        OP_NEG   = 5'h0c, OP_SBR   = 5'h0d, OP_CBR   = 5'h0e, OP_INC   = 5'h0f,
        OP_DEC   = 5'h10, OP_TST   = 5'h11, OP_CLR   = 5'h12, OP_SER   = 5'h13,
        OP_IOSET = 5'h14, OP_IOCLR = 5'h15
    } alu_op_t;
endpackage

// [hdl/alu_if.sv]
`timescale 1ns/100ps
interface alu_if;
    import alu_pkg::*;
    alu_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] k;
    logic [7:0] flags_in;
    logic [7:0] res;
    logic [7:0] flags_out;
    logic       wr_dest;
    modport core (input op, a, b, k, flags_in, output res, flags_out, wr_dest);
    modport user (output op, a, b, k, flags_in, input res, flags_out, wr_dest);
endinterface

// [hdl/alu_core.sv]
`timescale 1ns/100ps
module alu_core (
    alu_if.core bus // Operands in, result and flags out
);
    import alu_pkg::*;
    logic       arith;
    logic       sub;
    logic       lgc;
    logic       incdec;
    logic       cin;
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] r;
    logic [7:0] f;
    logic [8:0] wide;

    // ************************************************************
    // Result and flag update
    // ************************************************************
    always_comb
    begin
        arith = 1'b0;
        sub = 1'b0;
        lgc = 1'b0;
        incdec = 1'b0;
        cin = 1'b0;
        x = bus.a;
        y = bus.b;
        r = bus.a;
        f = bus.flags_in;
        wide = '0;
        bus.wr_dest = 1'b1;
        case (bus.op)
            OP_ADD  : arith = 1'b1;
            OP_ADC  : begin arith = 1'b1; cin = bus.flags_in[FLAG_C]; end
            OP_SUB  : begin arith = 1'b1; sub = 1'b1; end
            OP_DIFFERENCE_IMM : begin arith = 1'b1; sub = 1'b1; y = bus.k; end
            OP_SBC  : begin arith = 1'b1; sub = 1'b1; cin = bus.flags_in[FLAG_C]; end
            OP_BORROW_DIFFERENCE_IMM : begin arith = 1'b1; sub = 1'b1; y = bus.k; cin = bus.flags_in[FLAG_C]; end
            OP_NEG  : begin arith = 1'b1; sub = 1'b1; x = 8'h00; y = bus.a; end
            OP_AND  : begin lgc = 1'b1; r = bus.a & bus.b; end
            OP_CONJUNCTION_IMM : begin lgc = 1'b1; r = bus.a & bus.k; end
            OP_OR   : begin lgc = 1'b1; r = bus.a | bus.b; end
            OP_ORI  : begin lgc = 1'b1; r = bus.a | bus.k; end
            OP_EOR  : begin lgc = 1'b1; r = bus.a ^ bus.b; end
            OP_COM  : begin lgc = 1'b1; r = BYTE_ONES - bus.a; f[FLAG_C] = 1'b1; end
            OP_SBR  : begin lgc = 1'b1; r = bus.a | bus.k; end
            OP_CBR  : begin lgc = 1'b1; r = bus.a & (BYTE_ONES - bus.k); end
            OP_TST  : begin lgc = 1'b1; r = bus.a & bus.a; end
            OP_CLR  : begin lgc = 1'b1; r = bus.a ^ bus.a; end
            OP_INC  : begin incdec = 1'b1; r = 8'(bus.a + 8'h01); f[FLAG_V] = (r == 8'h80); end
            OP_DEC  : begin incdec = 1'b1; r = 8'(bus.a - 8'h01); f[FLAG_V] = (r == 8'h7f); end
            OP_SER  : r = BYTE_ONES;
            default : bus.wr_dest = 1'b0;
        endcase
        // Shared adder for add, subtract and negate
        if (arith)
        begin
            if (sub)
                wide = {1'b0, x} - {1'b0, y} - 9'(cin);
            else
                wide = {1'b0, x} + {1'b0, y} + 9'(cin);
            r = wide[7:0];
            if (sub)
            begin
                f[FLAG_H] = (~x[3] & y[3]) | (y[3] & r[3]) | (r[3] & ~x[3]);
                f[FLAG_C] = (~x[7] & y[7]) | (y[7] & r[7]) | (r[7] & ~x[7]);
                f[FLAG_V] = (x[7] & ~y[7] & ~r[7]) | (~x[7] & y[7] & r[7]);
            end
            else
            begin
                f[FLAG_H] = (x[3] & y[3]) | (y[3] & ~r[3]) | (~r[3] & x[3]);
                f[FLAG_C] = (x[7] & y[7]) | (y[7] & ~r[7]) | (~r[7] & x[7]);
                f[FLAG_V] = (x[7] & y[7] & ~r[7]) | (~x[7] & ~y[7] & r[7]);
            end
        end
        // Logic forms clear overflow
        if (lgc)
            f[FLAG_V] = 1'b0;
        // Zero, negative and sign for all flag-setting forms
        if (arith || lgc || incdec)
        begin
            f[FLAG_Z] = (r == 8'h00);
            f[FLAG_N] = r[7];
            f[FLAG_S] = r[7] ^ f[FLAG_V];
        end
        bus.res = r;
        bus.flags_out = f;
    end
endmodule

// [bench/core_drv.sv]
`timescale 1ns/100ps
// Decoder-side master, one write and one read at a time
module core_drv (
    input  wire logic        aclk,                                     // Core clock
    output logic [8:0]       awaddr, araddr,                           // Addresses
    output logic [31:0]      wdata,                                    // Write data
    output logic             awvalid, wvalid, bready, arvalid, rready, // Master side
    input  wire logic        awready, wready, bvalid, arready, rvalid, // Slave side
    input  wire logic [31:0] rdata,                                    // Read data
    input  wire logic [1:0]  rresp                                     // Read response
);
    // Idle bus from time zero
    initial {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    // Write: each channel dropped when taken, bready held until the response
    task automatic wr(input logic [8:0] a, input logic [31:0] d);
        @(posedge aclk);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do begin @(posedge aclk); if (awready) awvalid <= 1'b0; if (wready) wvalid <= 1'b0; end while (!bvalid);
        bready <= 1'b0;
    endtask
    // Read: byte and response code taken at the handshake edge
    task automatic rd(input logic [8:0] a, output logic [7:0] d, output logic [1:0] r);
        @(posedge aclk);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do begin @(posedge aclk); if (arready) arvalid <= 1'b0; end while (!rvalid);
        {d, r} = {rdata[7:0], rresp};
        rready <= 1'b0;
    endtask
endmodule

// [bench/alu_flag_datapath_tb.sv]
`timescale 1ns/100ps
module alu_flag_datapath_tb;
    import alu_pkg::*;
    logic        aclk = 1'b0, aresetn = 1'b0, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready;
    logic [8:0]  awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [7:0]  io_flag_events = 8'h00, dest_value, flag_register, rv;
    logic [1:0]  rresp, rs, bresp;
    int          failures = 0, n_checks = 0;
    // Row per op code 00 to 13: flags in, dest, src, imm, dest out, flags out
    logic [47:0] rows [20] = '{48'h00_08_08_00_10_20, 48'h01_7f_00_00_80_2c, 48'h00_00_01_00_ff_35,
        48'h00_80_00_01_7f_38, 48'h01_05_05_00_ff_35, 48'h01_10_00_0f_00_22, 48'h21_f0_80_00_80_35,
        48'h29_0f_00_f0_00_23, 48'h00_01_80_00_81_14, 48'h00_00_00_00_00_02, 48'h21_aa_aa_00_00_23,
        48'h20_00_00_00_ff_35, 48'h00_80_00_00_80_0d, 48'h01_40_00_01_41_01, 48'h00_ff_00_7f_80_14,
        48'h01_7f_00_00_80_0d, 48'h01_80_00_00_7f_19, 48'h08_00_00_00_00_02, 48'h04_55_00_00_00_02,
        48'h3f_00_00_00_ff_3f};
    logic [8:0]  offs [4] = '{STATUS_OFF, DEST_OFF, SRC_OFF, IMM_OFF};
    // 100 MHz clock
    always #5 aclk = ~aclk;
    alu_flag_datapath dut_u (.aclk, .aresetn, .awaddr, .awprot(3'h0), .awvalid, .awready, .wdata, .wstrb(4'h1),
        .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arprot(3'h0), .arvalid, .arready, .rdata,
        .rresp, .rvalid, .rready, .io_flag_events, .dest_value, .flag_register);
    core_drv drv_u (.aclk, .awaddr, .araddr, .wdata, .awvalid, .wvalid, .bready, .arvalid, .rready, .awready,
        .wready, .bvalid, .arready, .rvalid, .rdata, .rresp);
    // Compare one byte and count it
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin failures++; $display("[ERR] %0t got %h want %h", $time, got, exp); end
    endtask
    task automatic rchk(input logic [8:0] a, input logic [7:0] exp);
        drv_u.rd(a, rv, rs);
        chk(rv, exp);
    endtask
    task automatic finish_test;
        if (failures == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Watchdog
    initial begin #100000; failures++; finish_test(); end
    // Main sequence
    initial
    begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(STATUS_OFF, REG_RST);
        for (int i = 0; i < 20; i++)
        begin
            for (int j = 0; j < 4; j++) drv_u.wr(offs[j], 32'(rows[i][47-8*j -: 8]));
            drv_u.wr(CMD_OFF, 32'(i));
            chk(8'(bresp), 8'(RESP_OKAY));
            chk(dest_value, rows[i][15:8]);
            chk(flag_register, rows[i][7:0]);
        end
        // Clear-on-one byte: hardware sets, a written one clears, a bit op rewrites
        io_flag_events <= 8'h90;
        @(posedge aclk);
        io_flag_events <= 8'h00;
        drv_u.wr(9'h114, 32'h80);
        rchk(9'h114, 8'h10);
        drv_u.wr(CMD_OFF, {16'h0005, 8'h00, 3'h0, OP_IOSET});
        rchk(9'h114, 8'h00);
        drv_u.wr(CMD_OFF, {16'h001f, 8'h03, 3'h0, OP_IOSET});
        rchk(9'h17c, 8'h08);
        drv_u.wr(CMD_OFF, {16'h001f, 8'h03, 3'h0, OP_IOCLR});
        rchk(9'h17c, 8'h00);
        drv_u.wr(CMD_OFF, {16'h0020, 8'h00, 3'h0, OP_IOSET});
        rchk(INFO_OFF, 8'h01);
        drv_u.rd(9'h014, rv, rs); // Unmapped place only read
        chk(8'(rs), 8'(RESP_SLVERR));
        // Reset in mid-run: dest and flags hold ff and 3f here, the refusal bit is set
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        chk(dest_value, REG_RST);
        chk(flag_register, REG_RST);
        rchk(INFO_OFF, 8'h00);
        finish_test();
    end
endmodule
